// ==== src/bte_pkg.sv ====
// Shared constants and types for the byte to ten-bit line encoder
package bte_pkg;

    // ==========================================================
    // Widths and field positions
    localparam int DATA_W = 8;
    localparam int CHAR_W = 10;
    localparam int SIX_W = 6;
    localparam int FOUR_W = 4;
    localparam int FIVE_HI = 7;
    localparam int FIVE_LO = 3;
    localparam int THREE_HI = 2;
    localparam int THREE_LO = 0;
    localparam int SIX_E = 1; // Bit e inside abcdei
    localparam int SIX_I = 0; // Bit i inside abcdei
    localparam int TAIL_W = 5;

    // ==========================================================
    // Disparity encoding and reset values
    localparam logic RD_NEG = 1'b0;
    localparam logic RD_POS = 1'b1;
    localparam logic RD_RESET = RD_NEG;
    localparam logic [TAIL_W-1:0] RUN_SEED = 5'h0a; // Alternating bits, no run

    // ==========================================================
    // Line limits
    localparam int RUN_MAX = 5;
    localparam int DSV_MAX = 6;

    // ==========================================================
    // Special three-bit codes for input 111
    localparam logic [FOUR_W-1:0] PRIMARY_SEVEN_CODE = 4'he;
    localparam logic [FOUR_W-1:0] ALTERNATE_SEVEN_CODE = 4'h7;

    // ==========================================================
    // Table entry types
    typedef enum logic [1:0] {POL_ANY, POL_POS, POL_NEG} bte_pol_e;

    typedef struct packed {
        bte_pol_e pol;
        logic [SIX_W-1:0] code;
    } bte_six_s;

    typedef struct packed {
        bte_pol_e pol;
        logic [FOUR_W-1:0] code;
    } bte_four_s;

endpackage

// ==== src/bte_subblock_sel.sv ====
// Sub-block code selector: primary or complement by running disparity
`timescale 1ns/10ps
module bte_subblock_sel #(
    parameter int W = 6
) (
    input wire logic [W-1:0] primary, // Primary code from the table
    input wire bte_pkg::bte_pol_e pol, // Listed entry polarity
    input wire logic rd_in, // Running disparity on entry
    output logic [W-1:0] code, // Selected code
    output logic rd_out // Running disparity on exit
);

    // ==========================================================
    // Selection and disparity update
    // Every alternate in both tables is the bitwise complement of its primary
    always_comb begin
        int ones;
        logic use_primary;
        ones = 0;
        use_primary = (pol == bte_pkg::POL_ANY) ||
                      ((pol == bte_pkg::POL_POS) && (rd_in == bte_pkg::RD_POS)) ||
                      ((pol == bte_pkg::POL_NEG) && (rd_in == bte_pkg::RD_NEG));
        code = use_primary ? primary : ~primary;
        for (int k = 0; k < W; k++) begin
            ones = ones + {31'd0, code[k]};
        end
        // Zero-disparity codes keep the entry polarity
        if (2 * ones > W) begin
            rd_out = bte_pkg::RD_POS;
        end else if (2 * ones < W) begin
            rd_out = bte_pkg::RD_NEG;
        end else begin
            rd_out = rd_in;
        end
    end

endmodule

// ==== src/bte_encoder.sv ====
// Byte to ten-bit character encoder with running disparity
`timescale 1ns/10ps

// Operation
// - Every accepted byte becomes exactly one ten-bit character on the output.
// - Bits 7:3 map to abcdei through the fixed 32-entry five-to-six table.
// - Bits 2:0 map to fghj through the fixed three-to-four table.
// - Running disparity follows the polarity of the last non-zero sub-block.
// - Listed polarity match, or an independent entry, selects the primary code.
// - A polarity mismatch selects the alternate code of opposite disparity.
// - Each six-bit and four-bit sub-block has disparity zero, plus two or minus two.
// - Non-zero disparity sub-blocks alternate polarity across all boundaries.
// - Input 11100 and input 110 take complementary codes chosen by disparity.
// - Input 111 uses the 0111/1000 pair after e=i=1 with negative or e=i=0 with positive.
// - The bit stream never holds more than five identical bits in a row.
// - The digital sum variation of the stream stays within six.
// - Running disparity is held in a flip-flop updated on every character.
// - Character bits run a,b,c,d,e,i,f,g,h,j from bit 9 down, a sent first.
module bte_encoder (
    input wire logic clk, // 200 MHz character clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic clk_en, // Freezes all state while low
    input wire logic byte_valid, // Byte present this cycle
    input wire logic [7:0] byte_data, // Byte to encode
    output logic char_valid, // Character updated last enabled edge
    output logic [9:0] char_data, // Character, bit 9 is a
    output logic running_disp // Current disparity, 1 positive
);

    // ==========================================================
    // Table lookups
    // Primary table codes, of disparity zero, plus two or minus two
    function automatic bte_pkg::bte_six_s six_lookup(input logic [4:0] v);
        bte_pkg::bte_six_s r;
        r.pol = bte_pkg::POL_ANY;
        r.code = 6'h00;
        case (v)
            5'h00: r = '{bte_pkg::POL_POS, 6'h18};
            5'h10: r = '{bte_pkg::POL_POS, 6'h22};
            5'h08: r = '{bte_pkg::POL_POS, 6'h12};
            5'h18: r = '{bte_pkg::POL_ANY, 6'h31};
            5'h04: r = '{bte_pkg::POL_POS, 6'h0a};
            5'h14: r = '{bte_pkg::POL_ANY, 6'h29};
            5'h0c: r = '{bte_pkg::POL_ANY, 6'h19};
            5'h1c: r = '{bte_pkg::POL_NEG, 6'h38};
            5'h02: r = '{bte_pkg::POL_POS, 6'h06};
            5'h12: r = '{bte_pkg::POL_ANY, 6'h25};
            5'h0a: r = '{bte_pkg::POL_ANY, 6'h15};
            5'h1a: r = '{bte_pkg::POL_ANY, 6'h34};
            5'h06: r = '{bte_pkg::POL_ANY, 6'h0d};
            5'h16: r = '{bte_pkg::POL_ANY, 6'h2c};
            5'h0e: r = '{bte_pkg::POL_ANY, 6'h1c};
            5'h1e: r = '{bte_pkg::POL_POS, 6'h28};
            5'h01: r = '{bte_pkg::POL_NEG, 6'h1b};
            5'h11: r = '{bte_pkg::POL_ANY, 6'h23};
            5'h09: r = '{bte_pkg::POL_ANY, 6'h13};
            5'h19: r = '{bte_pkg::POL_ANY, 6'h32};
            5'h05: r = '{bte_pkg::POL_ANY, 6'h0b};
            5'h15: r = '{bte_pkg::POL_ANY, 6'h2a};
            5'h0d: r = '{bte_pkg::POL_ANY, 6'h1a};
            5'h1d: r = '{bte_pkg::POL_NEG, 6'h3a};
            5'h03: r = '{bte_pkg::POL_POS, 6'h0c};
            5'h13: r = '{bte_pkg::POL_ANY, 6'h26};
            5'h0b: r = '{bte_pkg::POL_ANY, 6'h16};
            5'h1b: r = '{bte_pkg::POL_NEG, 6'h36};
            5'h07: r = '{bte_pkg::POL_ANY, 6'h0e};
            5'h17: r = '{bte_pkg::POL_NEG, 6'h2e};
            5'h0f: r = '{bte_pkg::POL_NEG, 6'h1e};
            5'h1f: r = '{bte_pkg::POL_NEG, 6'h2b};
            default: r = '{bte_pkg::POL_ANY, 6'h00};
        endcase
        return r;
    endfunction

    // Input 111 needs the previous six bits and disparity, handled by the caller
    function automatic bte_pkg::bte_four_s four_lookup(input logic [2:0] v, input logic alt7);
        bte_pkg::bte_four_s r;
        r.pol = bte_pkg::POL_ANY;
        r.code = 4'h0;
        case (v)
            3'h0: r = '{bte_pkg::POL_POS, 4'h4};
            3'h4: r = '{bte_pkg::POL_ANY, 4'h9};
            3'h2: r = '{bte_pkg::POL_ANY, 4'h5};
            3'h6: r = '{bte_pkg::POL_NEG, 4'hc};
            3'h1: r = '{bte_pkg::POL_POS, 4'h2};
            3'h5: r = '{bte_pkg::POL_ANY, 4'ha};
            3'h3: r = '{bte_pkg::POL_ANY, 4'h6};
            3'h7: begin
                // Plain if keeps each pattern in an assignment context
                if (alt7) begin
                    r = '{bte_pkg::POL_NEG, bte_pkg::ALTERNATE_SEVEN_CODE};
                end else begin
                    r = '{bte_pkg::POL_NEG, bte_pkg::PRIMARY_SEVEN_CODE};
                end
            end
            default: r = '{bte_pkg::POL_ANY, 4'h0};
        endcase
        return r;
    endfunction

    // ==========================================================
    // Combinational encode path
    bte_pkg::bte_six_s six_entry;
    bte_pkg::bte_four_s four_entry;
    logic [5:0] six_code;
    logic [3:0] four_code;
    logic rd_after_six;
    logic rd_after_four;
    logic use_alt7;
    logic rd;

    assign six_entry = six_lookup(byte_data[bte_pkg::FIVE_HI:bte_pkg::FIVE_LO]);

    bte_subblock_sel #(.W(bte_pkg::SIX_W)) u_six_sel (
        .primary(six_entry.code),
        .pol(six_entry.pol),
        .rd_in(rd),
        .code(six_code),
        .rd_out(rd_after_six)
    );

    // Alternate seven code after e=i=1 with negative or e=i=0 with positive disparity
    assign use_alt7 = (six_code[bte_pkg::SIX_E] && six_code[bte_pkg::SIX_I] &&
                       (rd_after_six == bte_pkg::RD_NEG)) ||
                      (!six_code[bte_pkg::SIX_E] && !six_code[bte_pkg::SIX_I] &&
                       (rd_after_six == bte_pkg::RD_POS));

    assign four_entry = four_lookup(byte_data[bte_pkg::THREE_HI:bte_pkg::THREE_LO], use_alt7);

    // Four-bit sub-block sees the disparity left by the six-bit one
    bte_subblock_sel #(.W(bte_pkg::FOUR_W)) u_four_sel (
        .primary(four_entry.code),
        .pol(four_entry.pol),
        .rd_in(rd_after_six),
        .code(four_code),
        .rd_out(rd_after_four)
    );

    // ==========================================================
    // Disparity state
    // Exit polarity of last non-zero sub-block
    // Disparity register advances once per character
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd <= bte_pkg::RD_RESET;
        end else if (clk_en && byte_valid) begin
            rd <= rd_after_four;
        end
    end

    assign running_disp = rd;

    // ==========================================================
    // Output character register
    // One character per byte
    // Bit 9 is a, bit 0 is j
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            char_valid <= 1'b0;
            char_data <= 10'h000;
        end else if (clk_en) begin
            char_valid <= byte_valid;
            if (byte_valid) begin
                char_data <= {six_code, four_code};
            end
        end
    end

    // ==========================================================
    // Checking helpers, read only by assertions
    logic [7:0] data_q;
    logic rd_entry;
    logic rd_mid;
    logic sent_any;
    logic [4:0] prev_tail;

    // Longest run of equal bits in a window
    function automatic int longest_run(input logic [14:0] w);
        int run;
        int best;
        run = 1;
        best = 1;
        for (int k = 13; k >= 0; k--) begin
            run = (w[k] == w[k+1]) ? run + 1 : 1;
            best = (run > best) ? run : best;
        end
        return best;
    endfunction

    // Running sum inside a character starting from the entry disparity
    function automatic logic dsv_ok(input logic [9:0] c, input logic start_pos);
        int s;
        logic ok;
        s = start_pos ? 1 : -1;
        ok = 1'b1;
        for (int k = 9; k >= 0; k--) begin
            s = c[k] ? s + 1 : s - 1;
            if (2 * s > bte_pkg::DSV_MAX || 2 * s < -bte_pkg::DSV_MAX) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    // Capture of what each output character was built from
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= 8'h00;
            rd_entry <= bte_pkg::RD_RESET;
            rd_mid <= bte_pkg::RD_RESET;
            sent_any <= 1'b0;
            prev_tail <= bte_pkg::RUN_SEED;
        end else if (clk_en && byte_valid) begin
            data_q <= byte_data;
            rd_entry <= rd;
            rd_mid <= rd_after_six;
            sent_any <= 1'b1;
            prev_tail <= sent_any ? char_data[4:0] : bte_pkg::RUN_SEED;
        end
    end

    // ==========================================================
    // Assertions
    a_zero_six_code: assert property (@(posedge clk) disable iff (!rst_n)
        char_valid && data_q[7:3] == 5'h00 |-> char_data[9:4] == (rd_entry ? 6'h18 : 6'h27))
        else $error("five-bit zero encoded wrongly");

    a_zero_four_code: assert property (@(posedge clk) disable iff (!rst_n)
        char_valid && data_q[2:0] == 3'h0 |-> char_data[3:0] == (rd_mid ? 4'h4 : 4'hb))
        else $error("three-bit zero encoded wrongly");

    a_rd_tracks_last: assert property (@(posedge clk) disable iff (!rst_n)
        char_valid |-> running_disp ==
            (($countones(char_data[3:0]) != 2) ? ($countones(char_data[3:0]) > 2) :
             ($countones(char_data[9:4]) != 3) ? ($countones(char_data[9:4]) > 3) :
             rd_entry))
        else $error("running disparity does not follow last sub-block");

    a_indep_primary: assert property (@(posedge clk) disable iff (!rst_n)
        char_valid && data_q[7:3] == 5'h18 |-> char_data[9:4] == 6'h31)
        else $error("independent entry not primary");

    a_six_alternates: assert property (@(posedge clk) disable iff (!rst_n)
        char_valid && $countones(char_data[9:4]) != 3 |->
            ($countones(char_data[9:4]) > 3) != rd_entry)
        else $error("six-bit polarity repeats entry disparity");

    a_subblock_balance: assert property (@(posedge clk) disable iff (!rst_n)
        char_valid |-> $countones(char_data[9:4]) inside {2, 3, 4} &&
            $countones(char_data[3:0]) inside {1, 2, 3})
        else $error("sub-block disparity out of range");

    a_four_alternates: assert property (@(posedge clk) disable iff (!rst_n)
        char_valid && $countones(char_data[3:0]) != 2 |->
            ($countones(char_data[3:0]) > 2) != rd_mid)
        else $error("four-bit polarity repeats entry disparity");

    a_seven_six_pair: assert property (@(posedge clk) disable iff (!rst_n)
        char_valid && data_q[7:3] == 5'h1c |-> char_data[9:4] == (rd_entry ? 6'h07 : 6'h38))
        else $error("five-bit 11100 pair wrong");

    a_three_four_pair: assert property (@(posedge clk) disable iff (!rst_n)
        char_valid && data_q[2:0] == 3'h6 |-> char_data[3:0] == (rd_mid ? 4'h3 : 4'hc))
        else $error("three-bit 110 pair wrong");

    a_alt_seven_use: assert property (@(posedge clk) disable iff (!rst_n)
        char_valid && data_q[2:0] == 3'h7 |->
            char_data[3:0] == ((char_data[5] && char_data[4] && !rd_mid) ? 4'h7 :
                               (!char_data[5] && !char_data[4] && rd_mid) ? 4'h8 :
                               rd_mid ? 4'h1 : 4'he))
        else $error("input 111 code choice wrong");

    a_run_length: assert property (@(posedge clk) disable iff (!rst_n)
        char_valid |-> longest_run({prev_tail, char_data}) <= bte_pkg::RUN_MAX)
        else $error("run of identical bits too long");

    a_sum_variation: assert property (@(posedge clk) disable iff (!rst_n)
        char_valid |-> dsv_ok(char_data, rd_entry))
        else $error("digital sum variation exceeded");

endmodule

// ==== dv/bte_link_rx_model.sv ====
// Remote decoder model: disparity, alternation, run length and sum variation
`timescale 1ns/10ps
module bte_link_rx_model (
    input wire logic clk, // Character clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic clk_en, // Encoder clock enable
    input wire logic char_valid, // Character present
    input wire logic [9:0] char_data, // Character, bit 9 sent first
    output logic rx_disp, // Decoder running disparity, 1 positive
    output int rx_errors, // Line faults seen
    output int rx_chars // Characters decoded
);
    // ==========================================================
    // Line state
    logic en_q;
    logic last_bit;
    int run_len;
    int level;
    int lvl_min;
    int lvl_max;

    // Judge one sub-block, sent msb first
    task automatic sub_block(input logic [5:0] bits, input int w);
        int d;
        d = 2 * $countones(bits) - w;
        if (d != 0 && d != 2 && d != -2) rx_errors++;
        if (d != 0) begin
            if ((d > 0) == rx_disp) rx_errors++;
            rx_disp = (d > 0);
        end
        for (int i = w - 1; i >= 0; i--) begin
            run_len = (bits[i] == last_bit) ? run_len + 1 : 1;
            last_bit = bits[i];
            level += bits[i] ? 1 : -1;
            lvl_min = (level < lvl_min) ? level : lvl_min;
            lvl_max = (level > lvl_max) ? level : lvl_max;
            if (run_len > 5) rx_errors++;
            if (lvl_max - lvl_min > 6) rx_errors++;
        end
    endtask

    // Decode only characters produced at an enabled edge; frozen ones repeat
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_disp = 1'b0;
            rx_errors = 0;
            rx_chars = 0;
            en_q = 1'b0;
            last_bit = 1'b0;
            run_len = 0;
            level = 0;
            lvl_min = 0;
            lvl_max = 0;
        end else begin
            if (char_valid && en_q) begin
                sub_block(char_data[9:4], 6);
                sub_block({2'h0, char_data[3:0]}, 4);
                rx_chars++;
            end
            en_q = clk_en;
        end
    end
endmodule

// ==== dv/byte_to_ten_bit_line_encoder_tb.sv ====
// Self-checking bench for the byte to ten-bit line encoder
`timescale 1ns/10ps
module byte_to_ten_bit_line_encoder_tb;
    // ==========================================================
    // Stimulus, observation and counters
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b0;
    logic byte_valid = 1'b0;
    logic [7:0] byte_data = 8'h00;
    logic char_valid, running_disp, rx_disp;
    logic [9:0] char_data;
    logic exp_rd = 1'b0;
    logic [9:0] last_exp = 10'h000;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_sent = 0;
    int rx_errors, rx_chars;
    // Primary codes indexed by the literal input field value
    localparam logic [5:0] SIX [32] = '{6'h18, 6'h1b, 6'h06, 6'h0c, 6'h0a, 6'h0b, 6'h0d, 6'h0e,
        6'h12, 6'h13, 6'h15, 6'h16, 6'h19, 6'h1a, 6'h1c, 6'h1e, 6'h22, 6'h23, 6'h25, 6'h26,
        6'h29, 6'h2a, 6'h2c, 6'h2e, 6'h31, 6'h32, 6'h34, 6'h36, 6'h38, 6'h3a, 6'h28, 6'h2b};
    localparam logic [3:0] FOUR [8] = '{4'h4, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha, 4'hc, 4'he};

    // 200 MHz clock
    always #2.5 clk = ~clk;

    bte_encoder dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .byte_valid(byte_valid),
        .byte_data(byte_data), .char_valid(char_valid), .char_data(char_data),
        .running_disp(running_disp));

    bte_link_rx_model rx (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .char_valid(char_valid),
        .char_data(char_data), .rx_disp(rx_disp), .rx_errors(rx_errors), .rx_chars(rx_chars));

    // ==========================================================
    // Reference encoding
    function automatic int disp(logic [5:0] c, int w);
        return 2 * $countones(c) - w;
    endfunction

    function automatic logic [10:0] ref_enc(logic [7:0] d, logic rd);
        logic [5:0] s;
        logic [3:0] f;
        s = SIX[d[7:3]];
        if ((disp(s, 6) > 0 && rd) || (disp(s, 6) < 0 && !rd) || (d[7:3] == 5'h1c && rd)) s = ~s;
        if (disp(s, 6) != 0) rd = (disp(s, 6) > 0);
        f = FOUR[d[2:0]];
        if (d[2:0] == 3'h7 && ((s[1:0] == 2'h3 && !rd) || (s[1:0] == 2'h0 && rd))) begin
            f = bte_pkg::ALTERNATE_SEVEN_CODE;
        end
        if ((disp({2'h0, f}, 4) > 0 && rd) || (disp({2'h0, f}, 4) < 0 && !rd) ||
            (d[2:0] == 3'h6 && rd)) f = ~f;
        if (disp({2'h0, f}, 4) != 0) rd = (disp({2'h0, f}, 4) > 0);
        return {rd, s, f};
    endfunction

    // ==========================================================
    // Shared tasks
    task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Present one byte, then judge the character one edge later
    task automatic send(input logic [7:0] d);
        logic [10:0] e;
        byte_valid = 1'b1;
        byte_data = d;
        @(posedge clk);
        #1;
        e = ref_enc(d, exp_rd);
        chk("char_data", char_data, e[9:0]);
        chk("running_disp", {9'h0, running_disp}, {9'h0, e[10]});
        chk("char_valid", {9'h0, char_valid}, 10'h001);
        exp_rd = e[10];
        last_exp = e[9:0];
        n_sent++;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_state;
        chk("reset char_valid", {9'h0, char_valid}, 10'h000);
        chk("reset char_data", char_data, 10'h000);
        chk("reset running_disp", {9'h0, running_disp}, 10'h000);
    endtask

    task automatic t_first_byte;
        send(8'h00);
        chk("first char", char_data, 10'h274);
        byte_valid = 1'b0;
        @(posedge clk);
        #1;
        chk("idle char_valid", {9'h0, char_valid}, 10'h000);
        chk("idle char_data", char_data, last_exp);
    endtask

    // Every byte back to back, then a scrambled order for other entry disparities
    task automatic t_sweep;
        for (int i = 0; i < 256; i++) send(i[7:0]);
        for (int i = 0; i < 256; i++) send(8'(i * 37));
    endtask

    // Clock enable low freezes outputs while a byte is offered
    task automatic t_freeze;
        send(8'h55);
        clk_en = 1'b0;
        byte_data = 8'haa;
        repeat (3) @(posedge clk);
        #1;
        chk("frozen char_data", char_data, last_exp);
        chk("frozen char_valid", {9'h0, char_valid}, 10'h001);
        chk("frozen disp", {9'h0, running_disp}, {9'h0, exp_rd});
        clk_en = 1'b1;
        send(8'haa);
        // Decoder takes a character one edge after it appears
        byte_valid = 1'b0;
        @(posedge clk);
        #1;
        chk("char count", 10'(rx_chars), 10'(n_sent));
    endtask

    // Reset in mid-stream clears at once and restarts from negative
    task automatic t_mid_reset;
        send(8'h0f);
        rst_n = 1'b0;
        #1;
        t_reset_state;
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        exp_rd = 1'b0;
        n_sent = 0;
        send(8'h00);
        chk("restart char", char_data, 10'h274);
        send(8'hfc);
        send(8'he7);
    endtask

    task automatic t_line_checks;
        // Idle one edge so the decoder has taken the last character
        byte_valid = 1'b0;
        @(posedge clk);
        #1;
        chk("line faults", 10'(rx_errors), 10'h000);
        chk("decoder disp", {9'h0, rx_disp}, {9'h0, exp_rd});
        chk("char count", 10'(rx_chars), 10'(n_sent));
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        clk_en = 1'b1;
        t_reset_state;
        t_first_byte;
        t_sweep;
        t_freeze;
        // Judge the line before reset wipes the decoder's counts
        t_line_checks;
        t_mid_reset;
        t_line_checks;
        end_sim;
    end

    // About 540 cycles expected; allow ample margin
    initial begin
        #20000;
        n_mismatch++;
        $display("[ERR] watchdog expected finish seen timeout");
        end_sim;
    end
endmodule
